// *** core/aux_motor_staging_sleep.sv ***
// Implementation choices: the address map and the strobed register port.
module aux_motor_staging_sleep
	import aux_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire reg_req_t    req,
	output      logic [31:0] rdata,
	input  wire logic [15:0] out_freq,
	input  wire logic [15:0] pid_freq,
	input  wire fault_in_t   fault_in,
	output      logic [2:0]  aux_en,
	output      logic [15:0] freq_cmd,
	output      logic        ramp_from_min,
	output      logic        trip,
	output      logic [7:0]  fault_code
);

	logic [15:0]  aux_start_freq;
	logic [15:0]  aux_stop_freq;
	logic [15:0]  aux_start_delay;
	logic [15:0]  aux_stop_delay;
	logic [15:0]  sleep_detect_time;
	logic [15:0]  sleep_freq;
	logic [15:0]  wakeup_freq;
	logic [15:0]  min_output_freq;
	logic [15:0]  low_bound_freq;
	logic         sleep_en;
	logic [23:0]  term_fn;
	logic [31:0]  tick_cnt;
	logic         tick;
	logic [15:0]  start_cnt;
	logic [15:0]  stop_cnt;
	logic [15:0]  slp_cnt;
	logic [1:0]   aux_count;
	logic [1:0]   n_on;
	logic [1:0]   stop_ptr;
	logic [2:0]   is_aux;
	logic [1:0]   win_ofs [N_AUX];
	sleep_state_t sstate;
	logic [7:0]   hist [HIST_N];
	logic [7:0]   next_code;

	// Software registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			aux_start_freq    <= 16'h0000;
			aux_stop_freq     <= 16'h0000;
			aux_start_delay   <= 16'h0000;
			aux_stop_delay    <= 16'h0000;
			sleep_detect_time <= 16'h0000;
			sleep_freq        <= 16'h0000;
			wakeup_freq       <= 16'h0000;
			min_output_freq   <= 16'h0000;
			low_bound_freq    <= 16'h0000;
			sleep_en          <= 1'b0;
			term_fn           <= 24'h000000;
		end else if (req.wr) begin
			unique case (req.addr)
				R_AUX_START: aux_start_freq    <= (req.wdata[15:0] > FREQ_MAX) ? FREQ_MAX : req.wdata[15:0];
				R_AUX_STOP:  aux_stop_freq     <= (req.wdata[15:0] > FREQ_MAX) ? FREQ_MAX : req.wdata[15:0];
				R_AUX_SDLY:  aux_start_delay   <= (req.wdata[15:0] > TIME_MAX_AUX) ? TIME_MAX_AUX : req.wdata[15:0];
				R_AUX_PDLY:  aux_stop_delay    <= (req.wdata[15:0] > TIME_MAX_AUX) ? TIME_MAX_AUX : req.wdata[15:0];
				R_SLP_TIME:  sleep_detect_time <= (req.wdata[15:0] > TIME_MAX_SLP) ? TIME_MAX_SLP : req.wdata[15:0];
				R_SLP_FREQ:  sleep_freq        <= req.wdata[15:0];
				R_WAKE_FREQ: wakeup_freq       <= req.wdata[15:0];
				R_MIN_FREQ:  min_output_freq   <= req.wdata[15:0];
				R_LOW_FREQ:  low_bound_freq    <= req.wdata[15:0];
				R_CTRL:      sleep_en          <= req.wdata[CTRL_SLEEP_EN];
				R_TERM_FN:   term_fn           <= req.wdata[23:0];
				default: ;
			endcase
		end
	end

	// Read port, data one cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata <= 32'h00000000;
		end else if (req.rd) begin
			unique case (req.addr)
				R_AUX_START: rdata <= {16'h0000, aux_start_freq};
				R_AUX_STOP:  rdata <= {16'h0000, aux_stop_freq};
				R_AUX_SDLY:  rdata <= {16'h0000, aux_start_delay};
				R_AUX_PDLY:  rdata <= {16'h0000, aux_stop_delay};
				R_SLP_TIME:  rdata <= {16'h0000, sleep_detect_time};
				R_SLP_FREQ:  rdata <= {16'h0000, sleep_freq};
				R_WAKE_FREQ: rdata <= {16'h0000, wakeup_freq};
				R_MIN_FREQ:  rdata <= {16'h0000, min_output_freq};
				R_LOW_FREQ:  rdata <= {16'h0000, low_bound_freq};
				R_CTRL:      rdata <= {31'h00000000, sleep_en};
				R_TERM_FN:   rdata <= {8'h00, term_fn};
				R_STATUS:    rdata <= {16'h0000, fault_code, 1'b0, trip, sstate, aux_count, n_on};
				R_FAULT_H01: rdata <= {16'h0000, hist[1], hist[0]};
				R_FAULT_H23: rdata <= {16'h0000, hist[3], hist[2]};
				default:     rdata <= 32'h00000000;
			endcase
		end
	end

	// 0.1 s time base
	always_ff @(posedge core_clk) begin
		if (rst || tick) begin
			tick_cnt <= 32'h00000000;
		end else begin
			tick_cnt <= tick_cnt + 32'h00000001;
		end
	end
	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

	// Count of terminals assigned an aux function, capped at three
	for (genvar i = 0; i < N_TERM; i++) begin : g_term
		assign is_aux[i] = (term_fn[8*i +: 8] >= FUNC_AUX1) && (term_fn[8*i +: 8] <= FUNC_AUX3);
	end
	always_comb begin
		aux_count = 2'(is_aux[0]) + 2'(is_aux[1]) + 2'(is_aux[2]);
	end

	// Aux staging: start and stop delays count ticks while the condition holds
	always_ff @(posedge core_clk) begin
		if (rst) begin
			start_cnt <= 16'h0000;
			stop_cnt  <= 16'h0000;
			n_on      <= 2'h0;
			stop_ptr  <= 2'h0;
		end else if (aux_start_freq == 16'h0000) begin
			start_cnt <= 16'h0000;
			stop_cnt  <= 16'h0000;
			n_on      <= 2'h0;
			stop_ptr  <= 2'h0;
		end else if (out_freq >= aux_start_freq && n_on < aux_count) begin
			stop_cnt <= 16'h0000;
			if (start_cnt >= aux_start_delay) begin
				n_on      <= n_on + 2'h1;
				start_cnt <= 16'h0000;
			end else if (tick) begin
				start_cnt <= start_cnt + 16'h0001;
			end
		end else if (out_freq <= aux_stop_freq && n_on != 2'h0) begin
			start_cnt <= 16'h0000;
			if (stop_cnt >= aux_stop_delay) begin
				n_on     <= n_on - 2'h1;
				stop_ptr <= (n_on == 2'h1 || stop_ptr + 2'h1 >= aux_count) ? 2'h0 : stop_ptr + 2'h1;
				stop_cnt <= 16'h0000;
			end else if (tick) begin
				stop_cnt <= stop_cnt + 16'h0001;
			end
		end else begin
			start_cnt <= 16'h0000;
			stop_cnt  <= 16'h0000;
		end
	end

	// Running motors form a window from stop_ptr that wraps at the motor count, so the first started stops first
	for (genvar m = 0; m < N_AUX; m++) begin : g_win
		assign win_ofs[m] = (2'(m) >= stop_ptr) ? 2'(m) - stop_ptr : 2'(m) + aux_count - stop_ptr;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			aux_en <= 3'b000;
		end else begin
			for (int k = 0; k < N_AUX; k++) begin
				aux_en[k] <= (2'(k) < aux_count) && (win_ofs[k] < n_on);
			end
		end
	end

	// Sleep / wake state machine
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sstate  <= ST_RUN;
			slp_cnt <= 16'h0000;
		end else if (!sleep_en) begin
			sstate  <= ST_RUN;
			slp_cnt <= 16'h0000;
		end else begin
			unique case (sstate)
				ST_RUN: begin
					slp_cnt <= 16'h0000;
					if (out_freq <= sleep_freq) begin
						sstate <= ST_DOZE;
					end
				end
				ST_DOZE: begin
					if (out_freq > sleep_freq) begin
						sstate <= ST_RUN;
					end else if (slp_cnt > sleep_detect_time) begin
						sstate  <= ST_SLEEP;
						slp_cnt <= 16'h0000;
					end else if (tick) begin
						slp_cnt <= slp_cnt + 16'h0001;
					end
				end
				ST_SLEEP: begin
					// Wake compare runs on the live PID command
					if (pid_freq <= wakeup_freq) begin
						slp_cnt <= 16'h0000;
					end else if (slp_cnt > sleep_detect_time) begin
						sstate  <= ST_WAKE;
						slp_cnt <= 16'h0000;
					end else if (tick) begin
						slp_cnt <= slp_cnt + 16'h0001;
					end
				end
				ST_WAKE: sstate <= ST_RUN;
			endcase
		end
	end

	// Frequency command selection
	always_ff @(posedge core_clk) begin
		if (rst) begin
			freq_cmd      <= 16'h0000;
			ramp_from_min <= 1'b0;
		end else begin
			ramp_from_min <= (sstate == ST_WAKE);
			if (trip) begin
				freq_cmd <= 16'h0000;
			end else if (sstate == ST_SLEEP) begin
				freq_cmd <= 16'h0000;
			end else if (sstate == ST_WAKE) begin
				freq_cmd <= min_output_freq;
			end else if (pid_freq < min_output_freq) begin
				freq_cmd <= (sstate == ST_DOZE) ? low_bound_freq : 16'h0000;
			end else if (pid_freq <= low_bound_freq) begin
				freq_cmd <= low_bound_freq;
			end else begin
				freq_cmd <= pid_freq;
			end
		end
	end

	// Fault priority: overcurrent, then IGBT, then bus overvoltage
	always_comb begin
		next_code = FLT_NONE;
		if (fault_in.overcurrent_fault) begin
			next_code = FLT_OC;
		end else if (fault_in.igbt_fault) begin
			next_code = FLT_IGBT;
		end else if (fault_in.bus_overvoltage_fault) begin
			next_code = FLT_OV;
		end
	end

	// Trip latches until software clears it; a new fault wins over the clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			trip       <= 1'b0;
			fault_code <= FLT_NONE;
			for (int j = 0; j < HIST_N; j++) begin
				hist[j] <= FLT_NONE;
			end
		end else if (next_code != FLT_NONE && (!trip || next_code != fault_code)) begin
			trip       <= 1'b1;
			fault_code <= next_code;
			hist[0]    <= next_code;
			for (int j = 1; j < HIST_N; j++) begin
				hist[j] <= hist[j-1];
			end
		end else if (req.wr && req.addr == R_CTRL && req.wdata[CTRL_FLT_CLR] && next_code == FLT_NONE) begin
			trip       <= 1'b0;
			fault_code <= FLT_NONE;
		end
	end

	a_fault_trips: assert property (@(posedge core_clk) disable iff (rst)
		(next_code != FLT_NONE) |=> trip && fault_code != FLT_NONE)
		else $error("fault did not trip");
	a_aux_disabled: assert property (@(posedge core_clk) disable iff (rst)
		(aux_start_freq == 16'h0000) [*2] |=> aux_en == 3'b000)
		else $error("aux motor on while disabled");
	a_aux_count_cap: assert property (@(posedge core_clk) disable iff (rst)
		n_on <= aux_count || $past(aux_count) != aux_count)
		else $error("more motors than terminals");
	a_start_step: assert property (@(posedge core_clk) disable iff (rst)
		(n_on > $past(n_on)) |-> $past(out_freq) >= $past(aux_start_freq))
		else $error("motor started below start frequency");
	a_stop_step: assert property (@(posedge core_clk) disable iff (rst)
		(n_on < $past(n_on) && $past(aux_start_freq) != 16'h0000) |-> $past(out_freq) <= $past(aux_stop_freq))
		else $error("motor stopped above stop frequency");
	a_sleep_zero: assert property (@(posedge core_clk) disable iff (rst)
		(sstate == ST_SLEEP && !trip) |=> freq_cmd == 16'h0000)
		else $error("nonzero command while asleep");
	a_doze_low: assert property (@(posedge core_clk) disable iff (rst)
		(sstate == ST_DOZE && !trip && pid_freq <= low_bound_freq) |=> freq_cmd == $past(low_bound_freq))
		else $error("doze did not hold lower bound");
	a_wake_ramp: assert property (@(posedge core_clk) disable iff (rst)
		(sstate == ST_WAKE && sleep_en) |=> ramp_from_min && sstate == ST_RUN)
		else $error("wake did not ramp from minimum");
	a_sleep_entry: assert property (@(posedge core_clk) disable iff (rst)
		(sstate == ST_SLEEP && $past(sstate) == ST_DOZE) |-> $past(out_freq) <= $past(sleep_freq))
		else $error("slept above sleep frequency");
	a_wake_entry: assert property (@(posedge core_clk) disable iff (rst)
		(sstate == ST_WAKE) |-> $past(pid_freq) > $past(wakeup_freq))
		else $error("woke below wake frequency");

endmodule

// *** core/aux_pkg.sv ***
package aux_pkg;

	// Frequencies in 0.01 Hz units, times in 0.1 s units
	localparam logic [15:0] FREQ_MAX     = 16'h9c40;
	localparam logic [15:0] TIME_MAX_AUX = 16'h8ca0;
	localparam logic [15:0] TIME_MAX_SLP = 16'hffdc;
	localparam int          CLK_HZ       = 100000000;
	localparam int          TENTH_SEC_HZ = 10;
	localparam int          TICK_CYCLES_DEF = CLK_HZ / TENTH_SEC_HZ;

	// Output terminal function codes for auxiliary motors
	localparam logic [7:0]  FUNC_AUX1 = 8'h10;
	localparam logic [7:0]  FUNC_AUX3 = 8'h12;
	localparam int          N_TERM    = 3;
	localparam int          N_AUX     = 3;
	localparam int          HIST_N    = 4;

	// Register offsets
	localparam logic [3:0] R_AUX_START = 4'h0;
	localparam logic [3:0] R_AUX_STOP  = 4'h1;
	localparam logic [3:0] R_AUX_SDLY  = 4'h2;
	localparam logic [3:0] R_AUX_PDLY  = 4'h3;
	localparam logic [3:0] R_SLP_TIME  = 4'h4;
	localparam logic [3:0] R_SLP_FREQ  = 4'h5;
	localparam logic [3:0] R_WAKE_FREQ = 4'h6;
	localparam logic [3:0] R_MIN_FREQ  = 4'h7;
	localparam logic [3:0] R_LOW_FREQ  = 4'h8;
	localparam logic [3:0] R_CTRL      = 4'h9;
	localparam logic [3:0] R_TERM_FN   = 4'ha;
	localparam logic [3:0] R_STATUS    = 4'hb;
	localparam logic [3:0] R_FAULT_H01 = 4'hc;
	localparam logic [3:0] R_FAULT_H23 = 4'hd;

	// Control bit positions
	localparam int CTRL_SLEEP_EN = 0;
	localparam int CTRL_FLT_CLR  = 1;

	// Fault codes
	localparam logic [7:0] FLT_NONE   = 8'h00;
	localparam logic [7:0] FLT_OC     = 8'h01;
	localparam logic [7:0] FLT_IGBT   = 8'h02;
	localparam logic [7:0] FLT_OV     = 8'h03;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_DOZE  = 2'b01,
		ST_SLEEP = 2'b11,
		ST_WAKE  = 2'b10
	} sleep_state_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic overcurrent_fault;
		logic igbt_fault;
		logic bus_overvoltage_fault;
	} fault_in_t;

endpackage

// *** verification/drive_plant_model.sv ***
module drive_plant_model
	import aux_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [15:0] target,
	input  wire logic        trip,
	output      logic [15:0] out_freq
);
	timeunit 1ns;
	timeprecision 1ps;

	// Generator settles in one cycle; a trip drops the output frequency to zero on the next edge
	always_ff @(posedge core_clk) begin
		if (rst || trip) begin
			out_freq <= 16'h0000;
		end else begin
			out_freq <= target;
		end
	end
endmodule

// *** verification/tb_aux_motor_staging_sleep.sv ***
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module tb_aux_motor_staging_sleep
	import aux_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TK = 4;
	logic        core_clk;
	logic        rst;
	reg_req_t    req;
	logic [31:0] rdata;
	logic [31:0] d;
	logic [15:0] target;
	logic [15:0] out_freq;
	logic [15:0] pid_freq;
	fault_in_t   fault_in;
	logic [2:0]  aux_en;
	logic [15:0] freq_cmd;
	logic        ramp_from_min;
	logic        trip;
	logic [7:0]  fault_code;
	logic [7:0]  codes [3];
	int          bad_count;
	int          n_compared;
	int          cycles;
	int          k;

	aux_motor_staging_sleep #(.TICK_CYCLES(TK)) dut_u (
		.core_clk      (core_clk),
		.rst           (rst),
		.req           (req),
		.rdata         (rdata),
		.out_freq      (out_freq),
		.pid_freq      (pid_freq),
		.fault_in      (fault_in),
		.aux_en        (aux_en),
		.freq_cmd      (freq_cmd),
		.ramp_from_min (ramp_from_min),
		.trip          (trip),
		.fault_code    (fault_code)
	);

	drive_plant_model plant_u (
		.core_clk (core_clk),
		.rst      (rst),
		.target   (target),
		.trip     (trip),
		.out_freq (out_freq)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Ceiling well above the thousand or so cycles the tests need
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			bad_count++;
			complete_run();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge core_clk);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask

	// Samples at the edge closing the cycle where read data stand
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		req.rd <= 1'b0;
		@(posedge core_clk);
		d = rdata;
	endtask

	task automatic wait_en(input logic [2:0] e);
		k = 0;
		while (aux_en !== e && k < 40) begin
			cyc(1);
			k++;
		end
	endtask

	initial begin
		rst = 1'b1;
		req = '0;
		target = 16'h0000;
		pid_freq = 16'h0000;
		fault_in = '0;
		bad_count = 0;
		n_compared = 0;
		cycles = 0;
		codes = '{FLT_OC, FLT_IGBT, FLT_OV};
		cyc(4);
		rst <= 1'b0;
		rd(R_STATUS);
		`CHK("status", 32'h0, d)
		rd(4'hf);
		`CHK("unmapped", 32'h0, d)
		wr(R_AUX_START, 32'hffff);
		rd(R_AUX_START);
		`CHK("start sat", {16'h0, FREQ_MAX}, d)
		$display("test registers done");

		wr(R_TERM_FN, 32'h00001110);
		wr(R_AUX_START, 32'h0);
		wr(R_AUX_SDLY, 32'h2);
		target <= 16'h1770;
		cyc(40);
		`CHK("aux off", 3'b000, aux_en)
		wr(R_AUX_STOP, 32'h07d0);
		wr(R_AUX_START, 32'h1388);
		cyc(3);
		`CHK("start wait", 3'b000, aux_en)
		wait_en(3'b001);
		`CHK("motor1", 3'b001, aux_en)
		wait_en(3'b011);
		`CHK("motor2", 3'b011, aux_en)
		cyc(30);
		`CHK("two max", 3'b011, aux_en)
		wr(R_AUX_PDLY, 32'h1);
		target <= 16'h05dc;
		cyc(2);
		`CHK("stop wait", 3'b011, aux_en)
		wait_en(3'b010);
		`CHK("stop1", 3'b010, aux_en)
		wait_en(3'b000);
		`CHK("stop2", 3'b000, aux_en)
		wr(R_TERM_FN, 32'h00121110);
		wr(R_AUX_PDLY, 32'h3);
		target <= 16'h1770;
		wait_en(3'b011);
		target <= 16'h05dc;
		wait_en(3'b010);
		`CHK("fifo stop", 3'b010, aux_en)
		target <= 16'h1770;
		wait_en(3'b110);
		`CHK("restart", 3'b110, aux_en)
		wait_en(3'b111);
		`CHK("three", 3'b111, aux_en)
		target <= 16'h05dc;
		wait_en(3'b101);
		`CHK("wrap stop", 3'b101, aux_en)
		wait_en(3'b000);
		`CHK("all off", 3'b000, aux_en)
		$display("test staging done");

		wr(R_MIN_FREQ, 32'h01f4);
		wr(R_LOW_FREQ, 32'h05dc);
		wr(R_SLP_FREQ, 32'h03e8);
		wr(R_WAKE_FREQ, 32'h0bb8);
		wr(R_SLP_TIME, 32'h2);
		pid_freq <= 16'h04b0;
		target <= 16'h0320;
		cyc(4);
		`CHK("off lower", 16'h05dc, freq_cmd)
		pid_freq <= 16'h012c;
		cyc(4);
		`CHK("off below", 16'h0000, freq_cmd)
		pid_freq <= 16'h1770;
		cyc(4);
		`CHK("off pass", 16'h1770, freq_cmd)
		pid_freq <= 16'h012c;
		wr(R_CTRL, 32'h1);
		cyc(3);
		`CHK("doze", 16'h05dc, freq_cmd)
		cyc(20);
		`CHK("sleep", 16'h0000, freq_cmd)
		rd(R_STATUS);
		`CHK("state", ST_SLEEP, d[5:4])
		pid_freq <= 16'h04b0;
		cyc(3);
		`CHK("sleep low", 16'h0000, freq_cmd)
		pid_freq <= 16'h0fa0;
		target <= 16'h0fa0;
		k = 0;
		while (ramp_from_min !== 1'b1 && k < 40) begin
			cyc(1);
			k++;
		end
		`CHK("wake time", 1'b1, k >= 2 * TK)
		`CHK("ramp", 1'b1, ramp_from_min)
		`CHK("wake min", 16'h01f4, freq_cmd)
		wr(R_CTRL, 32'h0);
		$display("test sleep done");

		for (int i = 0; i < 3; i++) begin
			fault_in <= fault_in_t'(3'b100 >> i);
			cyc(3);
			`CHK("trip", 1'b1, trip)
			`CHK("code", codes[i], fault_code)
			`CHK("cmd", 16'h0000, freq_cmd)
			wr(R_CTRL, 32'h2);
			cyc(1);
			`CHK("held", 1'b1, trip)
			fault_in <= '0;
			cyc(50 * TK);
			wr(R_CTRL, 32'h2);
			cyc(2);
			`CHK("cleared", 1'b0, trip)
		end
		rd(R_FAULT_H01);
		`CHK("hist01", {FLT_IGBT, FLT_OV}, d[15:0])
		rd(R_FAULT_H23);
		`CHK("hist23", {FLT_NONE, FLT_OC}, d[15:0])
		$display("test faults done");
		complete_run();
	end
endmodule
